// File: logic/nvm_irq_pkg.sv
// Package with register map, field positions, reset values and types of the NVM interrupt block.
package nvm_irq_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] CTRL_OFFSET     = 8'h00;
  localparam logic [7:0] FLAGS_OFFSET    = 8'h04;
  localparam logic [7:0] FLAG_CLR_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFFSET = 8'h0c;
  localparam logic [7:0] IRQ_CLR_OFFSET  = 8'h10;
  localparam logic [7:0] IRQ_EN_OFFSET   = 8'h14;
  localparam logic [7:0] STACK_OFFSET    = 8'h18;

  // Control register field positions.
  localparam int GIE_BIT     = 0;
  localparam int NVM_EN_BIT  = 1;
  localparam int GRP_EN_BIT  = 2;

  // Flag register field positions.
  localparam int NVM_FLAG_BIT = 0;
  localparam int GRP_FLAG_BIT = 1;

  // Interrupt status field positions.
  localparam int EV_TAKEN_BIT = 0;
  localparam int EV_WAKE_BIT  = 1;
  localparam int EV_OVF_BIT   = 2;
  localparam int EV_WIDTH     = 3;

  // Reset values.
  localparam logic [2:0]          CTRL_RESET = 3'h0;
  localparam logic [EV_WIDTH-1:0] EV_RESET   = 3'h0;

  // Return stack depth and program counter width.
  localparam int STACK_DEPTH = 4;
  localparam int PTR_W       = 3;
  localparam int PC_W        = 12;
  localparam logic [PC_W-1:0] GROUP_VECTOR = 12'h014;

  // Sequencer requests toward the stack.
  typedef struct packed {
    logic call_op;
    logic subroutine_exit_op;
    logic interrupt_exit_op;
  } seq_req_t;

  // Stack operation decided by the controller.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH = 2'b01,
    ST_POP  = 2'b11
  } stack_op_t;

  // Power state of the core.
  typedef enum logic [1:0] {
    PW_RUN   = 2'b00,
    PW_IDLE  = 2'b01,
    PW_SLEEP = 2'b11
  } power_state_t;

endpackage

// File: logic/ret_stack.sv
// Return stack holding program counters only, in flip-flops addressed by a pointer.
`timescale 1ns/100ps
module ret_stack import nvm_irq_pkg::*; (
  input  wire logic            clk_in,     // System clock.
  input  wire logic            sys_rst_in, // Synchronous reset, high.
  input  wire stack_op_t       op_in,      // Push, pop or idle.
  input  wire logic [PC_W-1:0] push_pc_in, // Program counter to push.
  output logic [PC_W-1:0]      top_pc_out, // Entry at the top.
  output logic [PTR_W-1:0]     level_out,  // Used entries.
  output logic                 full_out    // No free entry left.
);

  logic [PC_W-1:0]  mem_q [STACK_DEPTH];
  logic [PTR_W-1:0] ptr_q;

  // Pointer moves on push and pop; overflow and underflow are refused.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ptr_q <= '0;
    end else if (op_in == ST_PUSH && ptr_q < PTR_W'(STACK_DEPTH)) begin
      ptr_q <= ptr_q + 1'b1;
    end else if (op_in == ST_POP && ptr_q != '0) begin
      ptr_q <= ptr_q - 1'b1;
    end
  end

  // Only the program counter is stored; no other register is saved.
  always_ff @(posedge clk_in) begin
    if (op_in == ST_PUSH && ptr_q < PTR_W'(STACK_DEPTH)) begin
      mem_q[ptr_q[PTR_W-2:0]] <= push_pc_in;
    end
  end

  assign top_pc_out = (ptr_q == '0) ? '0 : mem_q[2'(ptr_q - 1'b1)];
  assign level_out  = ptr_q;
  assign full_out   = (ptr_q == PTR_W'(STACK_DEPTH));

endmodule

// File: logic/nvm_irq_ctrl.sv
// Interrupt request, enable, service and wake-up logic for the NVM completion interrupt.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/100ps
// Functional notes
// RULE_01: The completion flag is set whenever an NVM erase or write cycle finishes.
// RULE_02: Vectoring needs the global enable, the NVM enable and the group enable all set.
// RULE_03: An enabled request calls the group vector only while the stack has a free entry.
// RULE_04: Taking the interrupt clears the global enable.
// RULE_05: Service clears only the group flag; software clears the NVM flag itself.
// RULE_06: Any rising request flag wakes the core from sleep or idle, enables aside.
// RULE_07: Software sets a flag before sleeping if that source must not wake the core.
// RULE_08: A set flag stays set until serviced or cleared by software, enable or not.
// RULE_09: Interrupt entry pushes only the program counter.
// RULE_10: The interrupt exit returns and sets the global enable again.
// RULE_11: The subroutine exit returns and leaves the global enable untouched.
// RULE_12: Software should avoid calls inside a service routine to spare the stack.
// RULE_13: A flag set event beats a software clear in the same cycle.
module nvm_irq_ctrl import nvm_irq_pkg::*; (
  input  wire logic            clk_in,          // System clock, 125 MHz.
  input  wire logic            sys_rst_in,      // Synchronous reset, high.
  input  wire logic            psel,            // APB select.
  input  wire logic            penable,         // APB access phase.
  input  wire logic            pwrite,          // APB write.
  input  wire logic [7:0]      paddr,           // APB byte address.
  input  wire logic [31:0]     pwdata,          // APB write data.
  output logic [31:0]          prdata,          // APB read data.
  output logic                 pready,          // APB ready.
  output logic                 pslverr,         // APB error on unmapped address.
  input  wire logic            nvm_erase_done_in, // Erase cycle ended, pulse.
  input  wire logic            nvm_write_done_in, // Write cycle ended, pulse.
  input  wire seq_req_t        seq_req_in,      // Sequencer call and exit requests.
  input  wire logic [PC_W-1:0] seq_pc_in,       // Return address of the current program.
  input  wire logic            sleep_req_in,    // Enter sleep, pulse.
  input  wire logic            idle_req_in,     // Enter idle, pulse.
  output logic                 vector_take_out, // Interrupt taken the cycle before, pulse, registered.
  output logic [PC_W-1:0]      vector_pc_out,   // Vector or return address, registered.
  output logic                 return_out,      // Return address valid, pulse, registered.
  output logic                 wake_out,        // Wake-up event, pulse, registered.
  output power_state_t         power_state_out, // Current power state.
  output logic                 irq_out          // Level interrupt to the host.
);

  logic [2:0]          ctrl_q;
  logic                nvm_flag_q;
  logic                grp_flag_q;
  logic                nvm_flag_prev_q;
  logic                grp_flag_prev_q;
  logic [EV_WIDTH-1:0] ev_stat_q;
  logic [EV_WIDTH-1:0] ev_en_q;
  power_state_t        pwr_q;
  logic                wake_q;
  logic [PC_W-1:0]     vec_pc_q;
  logic                ret_q;
  logic                take_q;
  stack_op_t           st_op;
  logic [PC_W-1:0]     top_pc;
  logic [PTR_W-1:0]    st_level;
  logic                st_full;
  logic                wr_en;
  logic                rd_en;
  logic                nvm_set;
  logic                nvm_clr;
  logic                take;
  logic                rise;
  logic                pend;
  logic                seq_busy;
  logic [EV_WIDTH-1:0] ev_set;

  // Address decode used only for the error response on unmapped addresses.
  function automatic logic known_addr(input logic [7:0] a);
    return a == CTRL_OFFSET || a == FLAGS_OFFSET || a == FLAG_CLR_OFFSET ||
           a == IRQ_STAT_OFFSET || a == IRQ_CLR_OFFSET || a == IRQ_EN_OFFSET ||
           a == STACK_OFFSET;
  endfunction

  // The slave answers in the first access cycle, with no wait state.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !known_addr(paddr);
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;

  // Event sources for the completion flag.
  assign nvm_set = nvm_erase_done_in || nvm_write_done_in; // [RULE_01]
  assign nvm_clr = wr_en && paddr == FLAG_CLR_OFFSET && pwdata[NVM_FLAG_BIT];

  // A request is pending only when every enable is set; the flags themselves need none.
  assign pend = ctrl_q[GIE_BIT] && ctrl_q[NVM_EN_BIT] && ctrl_q[GRP_EN_BIT] &&
                grp_flag_q && nvm_flag_q; // [RULE_02]
  // The stack has one port, so entry also waits a cycle while a call or a return uses it.
  assign seq_busy = |seq_req_in;
  // A full stack would lose the return address, so the call waits.
  assign take = pend && !st_full && pwr_q == PW_RUN && !seq_busy; // [RULE_03]

  // Wake on a rising flag, enables not consulted.
  assign rise = (nvm_flag_q && !nvm_flag_prev_q) || (grp_flag_q && !grp_flag_prev_q); // [RULE_06]

  // Stack traffic from interrupt entry, calls and both kinds of exit.
  always_comb begin
    st_op = ST_IDLE;
    if (take || seq_req_in.call_op) begin
      st_op = ST_PUSH; // [RULE_09]
    end else if (seq_req_in.subroutine_exit_op || seq_req_in.interrupt_exit_op) begin
      st_op = ST_POP;
    end
  end

  ret_stack u_stack (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .op_in      (st_op),
    .push_pc_in (seq_pc_in),
    .top_pc_out (top_pc),
    .level_out  (st_level),
    .full_out   (st_full)
  );

  // Completion flag holds until cleared by software; a same-cycle event wins.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      nvm_flag_q <= 1'b0;
    end else if (nvm_set) begin
      nvm_flag_q <= 1'b1; // [RULE_13]
    end else if (nvm_clr) begin
      nvm_flag_q <= 1'b0; // [RULE_08] [RULE_05]
    end
  end

  // Group flag follows the member flag and is cleared by service or software.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      grp_flag_q <= 1'b0;
    end else if (nvm_set) begin
      grp_flag_q <= 1'b1; // [RULE_13]
    end else if (take) begin
      grp_flag_q <= 1'b0; // [RULE_05]
    end else if (wr_en && paddr == FLAG_CLR_OFFSET && pwdata[GRP_FLAG_BIT]) begin
      grp_flag_q <= 1'b0; // [RULE_08]
    end
  end

  // Control enables; hardware entry and exit override a software write.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      if (wr_en && paddr == CTRL_OFFSET) begin
        ctrl_q <= pwdata[2:0];
      end
      if (take) begin
        ctrl_q[GIE_BIT] <= 1'b0; // [RULE_04]
      end else if (seq_req_in.interrupt_exit_op) begin
        ctrl_q[GIE_BIT] <= 1'b1; // [RULE_10]
      end
    end
  end

  // Previous flag values for the rising-edge wake detector.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      nvm_flag_prev_q <= 1'b0;
      grp_flag_prev_q <= 1'b0;
    end else begin
      nvm_flag_prev_q <= nvm_flag_q;
      grp_flag_prev_q <= grp_flag_q;
    end
  end

  // Power state; a rising flag returns the core to run.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pwr_q  <= PW_RUN;
      wake_q <= 1'b0;
    end else begin
      wake_q <= 1'b0;
      unique case (pwr_q)
        PW_RUN: begin
          if (sleep_req_in) begin
            pwr_q <= PW_SLEEP;
          end else if (idle_req_in) begin
            pwr_q <= PW_IDLE;
          end
        end
        PW_IDLE, PW_SLEEP: begin
          if (rise) begin
            pwr_q  <= PW_RUN; // [RULE_06]
            wake_q <= 1'b1;
          end
        end
        default: begin
          pwr_q <= PW_RUN;
        end
      endcase
    end
  end

  // Vector and return address toward the sequencer.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      vec_pc_q <= '0;
      ret_q    <= 1'b0;
      take_q   <= 1'b0;
    end else begin
      take_q <= take;
      ret_q  <= st_op == ST_POP && st_level != '0; // [RULE_11]
      if (take) begin
        vec_pc_q <= GROUP_VECTOR;
      end else if (st_op == ST_POP) begin
        vec_pc_q <= top_pc;
      end
    end
  end

  // Sticky event status; a new event wins over a same-cycle clear.
  assign ev_set = {st_full && seq_req_in.call_op, wake_q, take_q};
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ev_stat_q <= EV_RESET;
      ev_en_q   <= EV_RESET;
    end else begin
      if (wr_en && paddr == IRQ_EN_OFFSET) begin
        ev_en_q <= pwdata[EV_WIDTH-1:0];
      end
      if (wr_en && paddr == IRQ_CLR_OFFSET) begin
        ev_stat_q <= (ev_stat_q & ~pwdata[EV_WIDTH-1:0]) | ev_set;
      end else begin
        ev_stat_q <= ev_stat_q | ev_set;
      end
    end
  end

  // Read data is registered in the setup cycle and stands through the access.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prdata <= '0;
    end else if (rd_en) begin
      unique case (paddr)
        CTRL_OFFSET:     prdata <= {29'h0, ctrl_q};
        FLAGS_OFFSET:    prdata <= {30'h0, grp_flag_q, nvm_flag_q};
        IRQ_STAT_OFFSET: prdata <= {29'h0, ev_stat_q};
        IRQ_EN_OFFSET:   prdata <= {29'h0, ev_en_q};
        STACK_OFFSET:    prdata <= {27'h0, st_full, 1'b0, st_level};
        default:         prdata <= '0;
      endcase
    end
  end

  assign irq_out         = |(ev_stat_q & ev_en_q);
  assign vector_take_out = take_q;
  assign vector_pc_out   = vec_pc_q;
  assign return_out      = ret_q;
  assign wake_out        = wake_q;
  assign power_state_out = pwr_q;

  // Checks next to the logic.
  a_take_needs_enables: assert property ( // [RULE_02]
    @(posedge clk_in) disable iff (sys_rst_in)
    take |-> ctrl_q[GIE_BIT] && ctrl_q[NVM_EN_BIT] && ctrl_q[GRP_EN_BIT])
    else $error("Interrupt taken without all enables.");
  a_no_take_full: assert property ( // [RULE_03]
    @(posedge clk_in) disable iff (sys_rst_in)
    st_full |-> !take)
    else $error("Interrupt taken with full stack.");
  a_gie_cleared: assert property ( // [RULE_04]
    @(posedge clk_in) disable iff (sys_rst_in)
    take |=> !ctrl_q[GIE_BIT])
    else $error("Global enable not cleared on entry.");
  a_nvm_kept: assert property ( // [RULE_05]
    @(posedge clk_in) disable iff (sys_rst_in)
    take && !nvm_clr |=> nvm_flag_q && vector_take_out)
    else $error("Completion flag lost on service.");
  a_flag_set: assert property ( // [RULE_01]
    @(posedge clk_in) disable iff (sys_rst_in)
    nvm_set |=> nvm_flag_q)
    else $error("Completion flag not set.");
  a_flag_hold: assert property ( // [RULE_08]
    @(posedge clk_in) disable iff (sys_rst_in)
    nvm_flag_q && !nvm_clr |=> nvm_flag_q)
    else $error("Completion flag dropped.");
  a_wake_rise: assert property ( // [RULE_06]
    @(posedge clk_in) disable iff (sys_rst_in)
    pwr_q != PW_RUN && rise |=> wake_out && pwr_q == PW_RUN ##1 !wake_out)
    else $error("No wake on rising flag.");
  a_exit_gie: assert property ( // [RULE_10]
    @(posedge clk_in) disable iff (sys_rst_in)
    seq_req_in.interrupt_exit_op && !take |=> ctrl_q[GIE_BIT])
    else $error("Interrupt exit did not set global enable.");
  a_ret_keep: assert property ( // [RULE_11]
    @(posedge clk_in) disable iff (sys_rst_in)
    seq_req_in.subroutine_exit_op && !seq_req_in.interrupt_exit_op &&
    !(wr_en && paddr == CTRL_OFFSET) |=> $stable(ctrl_q[GIE_BIT]))
    else $error("Subroutine exit changed global enable.");
  a_set_wins: assert property ( // [RULE_13]
    @(posedge clk_in) disable iff (sys_rst_in)
    nvm_set && nvm_clr |=> nvm_flag_q)
    else $error("Clear beat a set.");
  a_push_pc: assert property ( // [RULE_09]
    @(posedge clk_in) disable iff (sys_rst_in)
    take |=> top_pc == $past(seq_pc_in))
    else $error("Pushed value not the PC.");
  a_take_pulse: assert property ( // [RULE_04]
    @(posedge clk_in) disable iff (sys_rst_in)
    vector_take_out |=> !vector_take_out)
    else $error("Second entry before the global enable was set again.");
  a_take_vector: assert property ( // [RULE_03]
    @(posedge clk_in) disable iff (sys_rst_in)
    take |=> vector_take_out && vector_pc_out == GROUP_VECTOR)
    else $error("Entry did not present the group vector.");
  a_grp_serviced: assert property ( // [RULE_05]
    @(posedge clk_in) disable iff (sys_rst_in)
    take && !nvm_set |=> !grp_flag_q)
    else $error("Group flag not cleared on service.");
  a_sw_clear: assert property ( // [RULE_05]
    @(posedge clk_in) disable iff (sys_rst_in)
    nvm_clr && !nvm_set |=> !nvm_flag_q)
    else $error("Software clear of the completion flag ignored.");
  a_stat_sticky: assert property ( // [RULE_08]
    @(posedge clk_in) disable iff (sys_rst_in)
    !(wr_en && paddr == IRQ_CLR_OFFSET) |=> (~ev_stat_q & $past(ev_stat_q)) == '0)
    else $error("Status bit dropped without a clear.");
  a_low_power_hold: assert property ( // [RULE_06]
    @(posedge clk_in) disable iff (sys_rst_in)
    pwr_q != PW_RUN && !rise |=> pwr_q == $past(pwr_q))
    else $error("Low-power state left without a rising flag.");
  a_push_level: assert property ( // [RULE_09]
    @(posedge clk_in) disable iff (sys_rst_in)
    take |=> st_level == $past(st_level) + 1'b1)
    else $error("Entry did not take one stack entry.");
  a_ret_valid: assert property ( // [RULE_10]
    @(posedge clk_in) disable iff (sys_rst_in)
    seq_req_in.interrupt_exit_op && !seq_req_in.call_op && st_level != '0 |=> return_out)
    else $error("Interrupt exit gave no return address.");
  a_ret_addr: assert property ( // [RULE_10]
    @(posedge clk_in) disable iff (sys_rst_in)
    st_op == ST_POP && st_level != '0 |=> vector_pc_out == $past(top_pc))
    else $error("Return address not the stacked one.");

  // Main scenarios that the bench is expected to reach.
  c_taken:   cover property (@(posedge clk_in) take);
  c_wake:    cover property (@(posedge clk_in) wake_q);
  c_interrupt_exit_op:    cover property (@(posedge clk_in) take ##[1:20] seq_req_in.interrupt_exit_op);
  c_full:    cover property (@(posedge clk_in) pend && st_full);
  c_set_clr: cover property (@(posedge clk_in) nvm_set && nvm_clr);

endmodule

// File: testbench/seq_model.sv
// Behavioural program sequencer that issues call and exit requests and follows jumps.
`timescale 1ns/100ps
module seq_model import nvm_irq_pkg::*; (
  input  wire logic            clk_in,     // System clock.
  input  wire logic            sys_rst_in, // Synchronous reset, high.
  input  wire logic [2:0]      cmd_in,     // Call, plain exit, interrupt exit pulses.
  input  wire logic            take_in,    // Interrupt taken.
  input  wire logic            return_in,  // Return address valid.
  input  wire logic [PC_W-1:0] target_in,  // Vector or return address.
  output seq_req_t             req_out,    // Requests toward the block.
  output logic [PC_W-1:0]      pc_out      // Current program counter.
);
  // Calls are issued only on command, so calls in a service routine are a test choice.
  always @(posedge clk_in) begin
    req_out <= sys_rst_in ? '0 : seq_req_t'(cmd_in);
  end
  // The counter only jumps, which makes every return address easy to predict.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      pc_out <= 12'h100;
    end else if (take_in || return_in) begin
      pc_out <= target_in;
    end
  end
endmodule

// File: testbench/tb.sv
// Self-checking bench for the NVM interrupt block with a behavioural sequencer.
`timescale 1ns/100ps
module tb import nvm_irq_pkg::*; ;
  logic            clk_in = 0;
  logic            sys_rst_in = 1;
  logic            psel = 0;
  logic            penable = 0;
  logic            pwrite = 0;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0;
  logic [31:0]     prdata;
  logic [31:0]     rdat;
  logic            pready;
  logic            pslverr;
  logic            rerr;
  logic [3:0]      pulses = 4'h0;
  logic [2:0]      cmd = 3'h0;
  seq_req_t        req;
  logic [PC_W-1:0] pc_now;
  logic            take;
  logic [PC_W-1:0] vec_pc;
  logic            ret_v;
  logic            wake;
  power_state_t    pstate;
  logic            irq;
  logic [PC_W-1:0] last_vec;
  int              takes = 0;
  int              wakes = 0;
  int              cyc = 0;
  int              num_errors = 0;
  int              total_checks = 0;

  always #4 clk_in = ~clk_in;

  nvm_irq_ctrl i_nvm_irq_ctrl (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nvm_erase_done_in(pulses[0]),
    .nvm_write_done_in(pulses[1]), .seq_req_in(req), .seq_pc_in(pc_now),
    .sleep_req_in(pulses[2]), .idle_req_in(pulses[3]), .vector_take_out(take),
    .vector_pc_out(vec_pc), .return_out(ret_v), .wake_out(wake),
    .power_state_out(pstate), .irq_out(irq));
  seq_model i_seq_model (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_in(cmd),
    .take_in(take), .return_in(ret_v), .target_in(vec_pc), .req_out(req), .pc_out(pc_now));

  // Counts takes and wake-ups, and cuts a hang short; the ceiling is over twenty times the run.
  always @(posedge clk_in) begin
    cyc++;
    if (take === 1'b1) begin
      takes++;
      last_vec = vec_pc;
    end
    if (wake === 1'b1) begin
      wakes++;
    end
    if (cyc >= 5000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One APB transfer; the optional pulse lands on the edge at which a write takes effect.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] p);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    pulses <= p;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pulses <= 4'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rdat, exp, $sformatf("read %h", a));
  endtask

  // Drives one-cycle pulses: bit 0 erase, 1 write, 2 sleep, 3 idle; bits 0-2 of c go to cmd.
  task automatic ev(input logic [3:0] p, input logic [2:0] c, input int settle);
    @(posedge clk_in);
    pulses <= p;
    cmd <= c;
    @(posedge clk_in);
    pulses <= 4'h0;
    cmd <= 3'h0;
    repeat (settle) @(posedge clk_in);
  endtask

  initial begin
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(CTRL_OFFSET, 32'h0);
    rd(IRQ_STAT_OFFSET, 32'h0);
    rd(STACK_OFFSET, 32'h0);
    apb(1'b0, 8'h1c, 32'h0, 4'h0);
    chk(32'(rerr), 32'h1, "unmapped error");
    ev(4'h1, 3'h0, 6);
    rd(FLAGS_OFFSET, 32'h3);
    wr(CTRL_OFFSET, 32'h3);
    ev(4'h0, 3'h0, 6);
    rd(FLAGS_OFFSET, 32'h3);
    chk(takes, 0, "take without group enable");
    wr(CTRL_OFFSET, 32'h7);
    ev(4'h0, 3'h0, 6);
    chk(takes, 1, "take");
    chk(32'(last_vec), 32'(GROUP_VECTOR), "vector");
    rd(CTRL_OFFSET, 32'h6);
    rd(FLAGS_OFFSET, 32'h1);
    rd(STACK_OFFSET, 32'h1);
    ev(4'h0, 3'b001, 6);
    chk(32'(pc_now), 32'h100, "return address");
    rd(CTRL_OFFSET, 32'h7);
    wr(FLAG_CLR_OFFSET, 32'h3);
    rd(FLAGS_OFFSET, 32'h0);
    ev(4'h2, 3'h0, 6);
    chk(takes, 2, "take after write");
    ev(4'h0, 3'b010, 6);
    rd(CTRL_OFFSET, 32'h6);
    ev(4'h2, 3'h0, 6);
    chk(takes, 2, "take after plain exit");
    wr(FLAG_CLR_OFFSET, 32'h3);
    apb(1'b1, FLAG_CLR_OFFSET, 32'h3, 4'h2);
    rd(FLAGS_OFFSET, 32'h3);
    wr(FLAG_CLR_OFFSET, 32'h3);
    // Fill the stack, then one call more, which is refused and recorded.
    for (int i = 0; i < 5; i++) ev(4'h0, 3'b100, 2);
    rd(STACK_OFFSET, 32'h14);
    rd(IRQ_STAT_OFFSET, 32'h5);
    wr(CTRL_OFFSET, 32'h7);
    ev(4'h1, 3'h0, 6);
    chk(takes, 2, "take with full stack");
    ev(4'h0, 3'b010, 6);
    chk(takes, 3, "take after a pop");
    wr(IRQ_EN_OFFSET, 32'h4);
    ev(4'h0, 3'h0, 1);
    chk(32'(irq), 32'h1, "irq enabled");
    wr(IRQ_EN_OFFSET, 32'h0);
    ev(4'h0, 3'h0, 1);
    chk(32'(irq), 32'h0, "irq masked");
    wr(IRQ_EN_OFFSET, 32'h4);
    wr(IRQ_CLR_OFFSET, 32'h4);
    ev(4'h0, 3'h0, 1);
    chk(32'(irq), 32'h0, "irq cleared");
    rd(IRQ_STAT_OFFSET, 32'h1);
    wr(CTRL_OFFSET, 32'h0);
    wakes = 0;
    // Idle then sleep, each left by a rising flag with every control enable off.
    for (int i = 0; i < 2; i++) begin
      wr(FLAG_CLR_OFFSET, 32'h3);
      ev(i ? 4'h4 : 4'h8, 3'h0, 3);
      chk(32'(pstate), i ? 32'(PW_SLEEP) : 32'(PW_IDLE), "low power");
      ev(i ? 4'h2 : 4'h1, 3'h0, 4);
      chk(wakes, i + 1, "wake count");
      chk(32'(pstate), 32'(PW_RUN), "running");
    end
    ev(4'h4, 3'h0, 3); // Flag still set before sleeping, as software should leave it.
    ev(4'h1, 3'h0, 4);
    chk(wakes, 2, "wake with flag set");
    chk(32'(pstate), 32'(PW_SLEEP), "still asleep");
    wr(FLAG_CLR_OFFSET, 32'h3);
    ev(4'h1, 3'h0, 4);
    chk(wakes, 3, "wake after clear");
    rd(IRQ_STAT_OFFSET, 32'h3);
    conclude();
  end
endmodule
